//--- design/rbfx_cfg.svh
// Constants for the register bit field extractor.
// Assumes inclusion by the package and the design modules only.
`ifndef RBFX_CFG_SVH
`define RBFX_CFG_SVH

`define RBFX_MAPS 16
`define RBFX_IDX_W 4
`define RBFX_REG_W 16
`define RBFX_WIDE_W 32
`define RBFX_SLV_W 8
`define RBFX_QTY_W 2
`define RBFX_QTY_ONE 2'h1
`define RBFX_QTY_TWO 2'h2
`define RBFX_ENTRY_W 58
`define RBFX_F_MASK_LO 0
`define RBFX_F_MASK_HI 31
`define RBFX_F_REG_LO 32
`define RBFX_F_REG_HI 47
`define RBFX_F_SLV_LO 48
`define RBFX_F_SLV_HI 55
`define RBFX_F_WIDE 56
`define RBFX_F_SWAP 57
`define RBFX_BYTE_HI_MASK 32'h0000FF00
`define RBFX_BYTE_LO_MASK 32'h000000FF
`define RBFX_NARROW_MASK 32'h0000FFFF
`define RBFX_ADDR_BIAS 16'h0001

`endif

//--- design/rbfx_pkg.sv
// Types for the register bit field extractor.
// Assumes rbfx_cfg.svh is on the include path.
`include "rbfx_cfg.svh"

package rbfx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOOK   = 3'b001,
    ST_DECIDE = 3'b010,
    ST_REQ    = 3'b011,
    ST_BEAT   = 3'b100
  } rbfx_state_e;

  typedef struct packed {
    rbfx_state_e st;
    logic [`RBFX_IDX_W-1:0] idx;
    logic [`RBFX_IDX_W-1:0] last;
    logic beat;
    logic [`RBFX_REG_W-1:0] first_word;
    logic cache_val;
    logic [`RBFX_REG_W-1:0] cache_reg;
    logic [`RBFX_SLV_W-1:0] cache_slv;
    logic cache_wide;
    logic cache_swap;
    logic [`RBFX_WIDE_W-1:0] cache_data;
  } rbfx_ctl_s;

  typedef struct packed {
    logic [`RBFX_MAPS-1:0][`RBFX_ENTRY_W-1:0] mem;
    logic [`RBFX_ENTRY_W-1:0] q;
  } rbfx_mem_s;

endpackage

//--- design/rbfx_map_mem.sv
// Map table: one entry per read map, registered read port.
// Assumes a single clock; ce freezes contents and read register.
`timescale 1ns/10ps
`default_nettype none
`include "rbfx_cfg.svh"

module rbfx_map_mem (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [`RBFX_IDX_W-1:0] waddr,
  input wire logic [`RBFX_ENTRY_W-1:0] wdata,
  // Read port, data one cycle after address
  input wire logic [`RBFX_IDX_W-1:0] raddr,
  output logic [`RBFX_ENTRY_W-1:0] rdata
);

  rbfx_pkg::rbfx_mem_s s_reg;
  rbfx_pkg::rbfx_mem_s s_next;

  // Read before write: same-cycle write shows next time
  always_comb
  begin
    s_next = s_reg;
    s_next.q = s_reg.mem[raddr];
    if (we)
    begin
      s_next.mem[waddr] = wdata;
    end
  end

  // No reset on the table; contents are loaded before use
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.q;

endmodule
`default_nettype wire

//--- design/rbfx_extractor.sv
// Read-map sequencer and bit field extractor for a bus master poller.
// Assumes a fetch engine that reads whole registers and returns beats.
`timescale 1ns/10ps
`default_nettype none
`include "rbfx_cfg.svh"

module rbfx_extractor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Map table load
  input wire logic cfg_we,
  input wire logic [`RBFX_IDX_W-1:0] cfg_idx,
  input wire logic [`RBFX_WIDE_W-1:0] cfg_mask,
  input wire logic [`RBFX_REG_W-1:0] cfg_regnum,
  input wire logic [`RBFX_SLV_W-1:0] cfg_slave,
  input wire logic cfg_wide,
  input wire logic cfg_swap,
  // Poll control
  input wire logic start,
  input wire logic [`RBFX_IDX_W-1:0] map_last,
  output logic busy,
  // Fetch engine
  output logic rd_req,
  output logic [`RBFX_SLV_W-1:0] rd_slave,
  output logic [`RBFX_REG_W-1:0] rd_addr,
  output logic [`RBFX_QTY_W-1:0] rd_qty,
  input wire logic rd_ack,
  input wire logic rd_valid,
  input wire logic [`RBFX_REG_W-1:0] rd_data,
  // Local object store
  output logic obj_we,
  output logic [`RBFX_IDX_W-1:0] obj_idx,
  output logic [`RBFX_WIDE_W-1:0] obj_value
);

  // Lowest set bit of a mask; zero for an empty mask
  // Scans from the top so the lowest set bit is the last to land
  function automatic logic [4:0] rbfx_low(input logic [`RBFX_WIDE_W-1:0] m);
    logic [4:0] sh;
    sh = 5'h00;
    for (int i = `RBFX_WIDE_W - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        sh = i[4:0];
      end
    end
    return sh;
  endfunction

  // Mask and right justify
  // Masks with gaps keep their gaps after the shift
  function automatic logic [`RBFX_WIDE_W-1:0] rbfx_extract(input logic [`RBFX_WIDE_W-1:0] d,
                                                         input logic [`RBFX_WIDE_W-1:0] m);
    return (d & m) >> rbfx_low(m);
  endfunction

  // Whole sequencer state, one packed struct
  rbfx_pkg::rbfx_ctl_s c_reg;
  rbfx_pkg::rbfx_ctl_s c_next;

  // Current map entry and its fields
  logic [`RBFX_ENTRY_W-1:0] ent;
  logic [`RBFX_WIDE_W-1:0] e_mask;
  logic [`RBFX_REG_W-1:0] e_reg;
  logic [`RBFX_SLV_W-1:0] e_slv;
  logic e_wide;
  logic e_swap;
  // Datapath and control nets
  logic [`RBFX_WIDE_W-1:0] mask_eff;
  logic share_hit;
  logic final_beat;
  logic [`RBFX_WIDE_W-1:0] fetched;
  logic [`RBFX_WIDE_W-1:0] data_sel;
  logic emit;

  // Table read address follows the current map
  // Read data arrives one cycle after the index moves
  rbfx_map_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(cfg_we),
    .waddr(cfg_idx),
    .wdata({cfg_swap, cfg_wide, cfg_slave, cfg_regnum, cfg_mask}),
    .raddr(c_reg.idx),
    .rdata(ent)
  );

  // Entry fields
  assign e_mask = ent[`RBFX_F_MASK_HI:`RBFX_F_MASK_LO];
  assign e_reg = ent[`RBFX_F_REG_HI:`RBFX_F_REG_LO];
  assign e_slv = ent[`RBFX_F_SLV_HI:`RBFX_F_SLV_LO];
  assign e_wide = ent[`RBFX_F_WIDE];
  assign e_swap = ent[`RBFX_F_SWAP];

  // Single registers see only the low sixteen mask bits
  // Stray upper mask digits on a narrow map are harmless
  assign mask_eff = e_wide ? e_mask : (e_mask & `RBFX_NARROW_MASK);

  // Same source as the last fetch: reuse the shared word
  // Slave, width and swap must match too, or the word means something else
  assign share_hit = c_reg.cache_val && (c_reg.cache_reg == e_reg) && (c_reg.cache_slv == e_slv) &&
                     (c_reg.cache_wide == e_wide) && (c_reg.cache_swap == e_swap);

  // Only beat of a narrow map, second beat of a pair
  assign final_beat = (c_reg.st == rbfx_pkg::ST_BEAT) && rd_valid && (!e_wide || c_reg.beat);

  // Pair assembly: lower-numbered register is the high half unless swapped
  always_comb
  begin
    if (!e_wide)
    begin
      fetched = {16'h0000, rd_data};
    end
    else if (e_swap)
    begin
      fetched = {rd_data, c_reg.first_word};
    end
    else
    begin
      fetched = {c_reg.first_word, rd_data};
    end
  end

  // Result is combinational so it lands with the valid data
  // The value means nothing while obj_we is low
  assign emit = ce && (final_beat || ((c_reg.st == rbfx_pkg::ST_DECIDE) && share_hit));
  assign data_sel = (c_reg.st == rbfx_pkg::ST_BEAT) ? fetched : c_reg.cache_data;
  assign obj_we = emit;
  assign obj_idx = c_reg.idx;
  assign obj_value = rbfx_extract(data_sel, mask_eff);

  // Fetch request; one outstanding at a time, no arbitration as sole master
  // Request fields come straight from the current entry
  assign rd_req = (c_reg.st == rbfx_pkg::ST_REQ);
  assign rd_slave = e_slv;
  assign rd_addr = e_reg - `RBFX_ADDR_BIAS;
  assign rd_qty = e_wide ? `RBFX_QTY_TWO : `RBFX_QTY_ONE;
  assign busy = (c_reg.st != rbfx_pkg::ST_IDLE);

  // Sequencer next state
  // Every map passes LOOK to cover the table read latency
  always_comb
  begin
    c_next = c_reg;
    unique case (c_reg.st)
      rbfx_pkg::ST_IDLE:
      begin
        if (start)
        begin
          c_next.idx = '0;
          c_next.last = map_last;
          c_next.cache_val = 1'b0; // Fresh poll cycle, stale data dropped
          c_next.st = rbfx_pkg::ST_LOOK;
        end
      end
      rbfx_pkg::ST_LOOK:
      begin
        c_next.st = rbfx_pkg::ST_DECIDE; // Table read latency
      end
      rbfx_pkg::ST_DECIDE:
      begin
        c_next.st = share_hit ? rbfx_pkg::ST_LOOK : rbfx_pkg::ST_REQ;
      end
      rbfx_pkg::ST_REQ:
      begin
        if (rd_ack)
        begin
          c_next.beat = 1'b0;
          c_next.st = rbfx_pkg::ST_BEAT;
        end
      end
      rbfx_pkg::ST_BEAT:
      begin
        // First word of a pair is parked until the second arrives
        if (rd_valid && e_wide && !c_reg.beat)
        begin
          c_next.first_word = rd_data;
          c_next.beat = 1'b1;
        end
        else if (rd_valid)
        begin
          c_next.cache_val = 1'b1;
          c_next.cache_reg = e_reg;
          c_next.cache_slv = e_slv;
          c_next.cache_wide = e_wide;
          c_next.cache_swap = e_swap;
          c_next.cache_data = fetched;
          c_next.st = rbfx_pkg::ST_LOOK;
        end
      end
      default:
      begin
        c_next.st = rbfx_pkg::ST_IDLE;
      end
    endcase
    // Advance after each stored result
    // The last map closes the pass, the others step the index
    if (final_beat || ((c_reg.st == rbfx_pkg::ST_DECIDE) && share_hit))
    begin
      if (c_reg.idx == c_reg.last)
      begin
        c_next.st = rbfx_pkg::ST_IDLE;
      end
      else
      begin
        c_next.idx = c_reg.idx + 4'h1;
      end
    end
  end

  // State register
  // Reset wins over ce so a frozen block can still be cleared
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      c_reg <= '0;
    end
    else if (ce)
    begin
      c_reg <= c_next;
    end
  end

  // All checks run on the one clock and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Fetch requests: whole registers, wire address one below the number
  AST_ADDR_MINUS_ONE: assert property (rd_req |-> (rd_addr + 16'h0001) == e_reg)
    else $error("wire address not register number minus one");
  AST_WHOLE_REG: assert property (rd_req |-> rd_qty == (e_wide ? 2'h2 : 2'h1))
    else $error("fetch quantity not whole registers");
  AST_REQ_HOLD: assert property (rd_req && !rd_ack |=> rd_req)
    else $error("request dropped before acknowledge");
  AST_REQ_STABLE: assert property (rd_req && !rd_ack |=> $stable(rd_addr) && $stable(rd_qty) &&
                                   $stable(rd_slave))
    else $error("request fields moved before acknowledge");
  AST_ACK_DROPS: assert property (ce && rd_req && rd_ack |=> !rd_req)
    else $error("request held after acknowledge");
  AST_IDLE_QUIET: assert property (!busy |-> !rd_req && !obj_we)
    else $error("fetch or result while idle");

  // Extraction: mask, right justify, single bits as 0 or 1
  AST_SINGLE_BIT: assert property (obj_we && $onehot(mask_eff) |->
                                   obj_value == {31'h0, |(data_sel & mask_eff)})
    else $error("single bit result not 0 or 1");
  AST_LOW_BIT: assert property (obj_we && mask_eff != 32'h0 |->
                                obj_value[0] == data_sel[rbfx_low(mask_eff)])
    else $error("lowest selected bit not at position zero");
  AST_MASK_ZERO: assert property (obj_we && mask_eff == 32'h0 |-> obj_value == 32'h0)
    else $error("empty mask gave a nonzero result");
  AST_NARROW: assert property (obj_we && !e_wide |-> obj_value[31:16] == 16'h0000)
    else $error("narrow result has high bits set");
  AST_BIT15: assert property (obj_we && mask_eff == 32'h00008000 |->
                              obj_value == {31'h0, data_sel[15]})
    else $error("top bit of a register not extracted");
  AST_BYTE_HI: assert property (obj_we && mask_eff == `RBFX_BYTE_HI_MASK |->
                                obj_value == {24'h0, data_sel[15:8]})
    else $error("upper byte extraction wrong");
  AST_BYTE_LO: assert property (obj_we && mask_eff == `RBFX_BYTE_LO_MASK |->
                                obj_value == {24'h0, data_sel[7:0]})
    else $error("lower byte extraction wrong");

  // Register pairs: high half from the lower register unless swapped
  AST_BIT31: assert property (obj_we && e_wide && mask_eff == 32'h80000000 |->
                              obj_value == {31'h0, data_sel[31]})
    else $error("top bit of a register pair not extracted");
  AST_PAIR_ORDER: assert property (obj_we && final_beat && e_wide && !e_swap |-> obj_value ==
                                   rbfx_extract({c_reg.first_word, rd_data}, e_mask))
    else $error("register pair order wrong");
  AST_SWAP_ORDER: assert property (obj_we && final_beat && e_wide && e_swap |-> obj_value ==
                                   rbfx_extract({rd_data, c_reg.first_word}, e_mask))
    else $error("swapped register pair order wrong");

  // Sharing and timing of results
  AST_FIRST_FETCH: assert property (ce && start && !busy |=> !c_reg.cache_val)
    else $error("shared word survived a new pass");
  AST_SHARE: assert property (ce && c_reg.st == rbfx_pkg::ST_DECIDE && share_hit |-> obj_we ##1 !rd_req)
    else $error("shared register fetched again");
  AST_SAME_CYCLE: assert property (ce && final_beat |-> obj_we)
    else $error("result not in cycle of valid data");
  AST_RESULT_GAP: assert property (obj_we |=> !obj_we)
    else $error("results closer than two cycles");

  // Main scenarios
  COV_SHARE: cover property (ce && c_reg.st == rbfx_pkg::ST_DECIDE && share_hit);
  COV_WIDE_SWAP: cover property (obj_we && final_beat && e_wide && e_swap);
  COV_BYTE_LO: cover property (obj_we && mask_eff == 32'h000000FF);
  COV_BIT15: cover property (obj_we && mask_eff == 32'h00008000 && obj_value == 32'h1);
  COV_FREEZE: cover property (!ce && busy);

endmodule
`default_nettype wire

//--- tb/rbfx_slave_model.sv
// Far-side fetch engine and remote slave for the extractor bench.
// Assumes requests held until ack and beats sampled on rising edges.
`timescale 1ns/10ps
`default_nettype none

module rbfx_slave_model #(
  parameter logic [7:0] SLV_ADDR = 8'h2A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Idle cycles before ack and between beats
  input wire logic [1:0] slow,
  // Request
  input wire logic rd_req,
  input wire logic [7:0] rd_slave,
  input wire logic [15:0] rd_addr,
  input wire logic [1:0] rd_qty,
  output logic rd_ack,
  // Return
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [7:0] fetches
);
  logic [15:0] mem [16];
  logic [15:0] ptr;
  logic [1:0] left;
  logic [1:0] dly;

  // Only answers, never polls by itself
  always_ff @(posedge clk)
  begin
    rd_valid <= 1'b0;
    rd_data <= ~rd_data; // Stale word never repeats
    if (!rstn)
    begin
      rd_ack <= 1'b0;
      rd_data <= 16'h0000;
      left <= 2'h0;
      dly <= 2'h0;
      fetches <= 8'h00;
    end
    else if (rd_ack)
    begin
      rd_ack <= 1'b0;
      left <= rd_qty;
      ptr <= rd_addr;
      fetches <= fetches + 8'h01;
      dly <= slow;
    end
    else if (left != 2'h0)
    begin
      if (dly != 2'h0)
        dly <= dly - 2'h1;
      else
      begin
        rd_valid <= 1'b1;
        rd_data <= mem[ptr[3:0]];
        ptr <= ptr + 16'h0001;
        left <= left - 2'h1;
        dly <= slow;
      end
    end
    else if (rd_req && rd_slave == SLV_ADDR)
    begin
      if (dly != 2'h0)
        dly <= dly - 2'h1;
      else
        rd_ack <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: extractor against the slave model.
// Assumes design files and slave model compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [15:0] W2 = 16'h7E81;
  localparam logic [15:0] W4 = 16'hA5C3;
  localparam logic [15:0] W6 = 16'h3CA5;
  localparam logic [15:0] W8 = 16'h8F3C;
  localparam logic [15:0] W9 = 16'h1E6B;
  logic clk, rstn, ce, cfg_we, cfg_wide, cfg_swap, start, busy, rd_req, rd_ack, rd_valid, obj_we;
  logic [3:0] cfg_idx, map_last, obj_idx;
  logic [31:0] cfg_mask, obj_value;
  logic [15:0] cfg_regnum, rd_addr, rd_data;
  logic [7:0] cfg_slave, rd_slave, fetches, f0;
  logic [1:0] rd_qty, slow;
  logic [31:0] res [16];
  logic at_v [16];
  int err_total = 0;
  int total_checks = 0;
  int nres = 0;
  int cycles = 0;

  rbfx_extractor dut (.clk(clk), .rstn(rstn), .ce(ce), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_mask(cfg_mask), .cfg_regnum(cfg_regnum), .cfg_slave(cfg_slave), .cfg_wide(cfg_wide),
    .cfg_swap(cfg_swap), .start(start), .map_last(map_last), .busy(busy), .rd_req(rd_req),
    .rd_slave(rd_slave), .rd_addr(rd_addr), .rd_qty(rd_qty), .rd_ack(rd_ack), .rd_valid(rd_valid),
    .rd_data(rd_data), .obj_we(obj_we), .obj_idx(obj_idx), .obj_value(obj_value));

  rbfx_slave_model slave (.clk(clk), .rstn(rstn), .slow(slow), .rd_req(rd_req), .rd_slave(rd_slave),
    .rd_addr(rd_addr), .rd_qty(rd_qty), .rd_ack(rd_ack), .rd_valid(rd_valid), .rd_data(rd_data),
    .fetches(fetches));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Capture results; rd_valid noted for same-cycle output
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (obj_we)
    begin
      res[obj_idx] <= obj_value;
      at_v[obj_idx] <= rd_valid;
      nres <= nres + 1;
    end
    if (cycles == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic set_map(input logic [3:0] i, input logic [31:0] m, input logic [15:0] r, input logic w,
                         input logic s);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_mask <= m;
    cfg_regnum <= r;
    cfg_slave <= 8'h2A;
    cfg_wide <= w;
    cfg_swap <= s;
  endtask

  // One pass over maps 0..last; wait bounded by a local count
  task automatic run(input logic [3:0] last, input logic [1:0] pace, input logic hold);
    int n;
    foreach (res[k]) res[k] = 32'hDEADBEEF;
    nres = 0;
    f0 = fetches;
    @(posedge clk);
    cfg_we <= 1'b0;
    slow <= pace;
    start <= 1'b1;
    map_last <= last;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk(32'(busy), 32'h1);
    // Freeze during shared results, while the slave is idle
    if (hold)
    begin
      for (n = 0; n < 300 && nres < 2; n++)
        @(posedge clk);
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(busy), 32'h1);
      chk(32'(nres), 32'h2);
      ce <= 1'b1;
    end
    for (n = 0; n < 3000 && busy !== 1'b0; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk(32'(busy), 32'h0);
    chk(32'(nres), 32'(last) + 32'h1);
  endtask

  task automatic t_bits;
    for (int i = 0; i < 16; i++)
      set_map(4'(i), 32'h1 << i, 16'h0005, 1'b0, 1'b0);
    run(4'hF, 2'h0, 1'b1);
    for (int i = 0; i < 16; i++)
      chk(res[i], {31'h0, W4[i]});
    chk(32'(fetches - f0), 32'h1);
    chk(32'(at_v[0]), 32'h1);
  endtask

  task automatic t_bytes;
    set_map(4'h0, 32'h0000FF00, 16'h0003, 1'b0, 1'b0);
    set_map(4'h1, 32'h000000FF, 16'h0003, 1'b0, 1'b0);
    set_map(4'h2, 32'h00000FF0, 16'h0007, 1'b0, 1'b0);
    set_map(4'h3, 32'hFFFF00F0, 16'h0007, 1'b0, 1'b0);
    run(4'h3, 2'h2, 1'b0);
    chk(res[0], {24'h0, W2[15:8]});
    chk(res[1], {24'h0, W2[7:0]});
    chk(res[2], {24'h0, W6[11:4]});
    chk(res[3], {28'h0, W6[7:4]});
    chk(32'(fetches - f0), 32'h2);
  endtask

  task automatic t_wide;
    set_map(4'h0, 32'h80000000, 16'h0009, 1'b1, 1'b0);
    set_map(4'h1, 32'h0000FFFF, 16'h0009, 1'b1, 1'b0);
    set_map(4'h2, 32'h00010000, 16'h0009, 1'b1, 1'b1);
    set_map(4'h3, 32'hFFFF0000, 16'h0009, 1'b1, 1'b1);
    run(4'h3, 2'h1, 1'b0);
    chk(res[0], {31'h0, W8[15]});
    chk(res[1], {16'h0, W9});
    chk(res[2], {31'h0, W9[0]});
    chk(res[3], {16'h0, W9});
    chk(32'(fetches - f0), 32'h2);
  endtask

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    cfg_we = 1'b0;
    cfg_idx = 4'h0;
    cfg_mask = 32'h0;
    cfg_regnum = 16'h0;
    cfg_slave = 8'h2A;
    cfg_wide = 1'b0;
    cfg_swap = 1'b0;
    start = 1'b0;
    map_last = 4'h0;
    slow = 2'h0;
    slave.mem[2] = W2;
    slave.mem[4] = W4;
    slave.mem[6] = W6;
    slave.mem[8] = W8;
    slave.mem[9] = W9;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_bits();
    t_bytes();
    t_wide();
    stop_test();
  end
endmodule

`default_nettype wire
